// ==== core/itf_pkg.sv ====
// constants, register map and carriers of the interval timer and flag block
// assumes one 100 MHz clock and a classic wishbone master with 32-bit data
package itf_pkg;

  // clock rates and time bases
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SYS_HZ = 50_000_000;
  localparam int unsigned TICK_HZ = 4_100_000;
  localparam int unsigned FINE_PERIOD_US = 10;
  localparam int unsigned EVENT_PERIOD_MS = 1;
  localparam int unsigned SYS_DIV = CLK_HZ / SYS_HZ;
  localparam int unsigned SYS_CNT_W = $clog2(SYS_DIV);
  localparam int unsigned FINE_TICKS = int'((64'(TICK_HZ) * FINE_PERIOD_US) / 64'd1_000_000);
  localparam int unsigned MS_TICKS = int'((64'(TICK_HZ) * EVENT_PERIOD_MS) / 64'd1_000);

  // fractional-n accumulator
  localparam int unsigned ACC_W = 32;
  localparam logic [ACC_W-1:0] ACC_INC = ACC_W'((64'(TICK_HZ) << ACC_W) / 64'(SYS_HZ));

  // timer widths
  localparam int unsigned PHASE_W = $clog2(MS_TICKS);
  localparam int unsigned SUB_W = $clog2(FINE_TICKS);
  localparam int unsigned FINE_W = 28;
  localparam int unsigned WORD_W = 36;
  localparam int unsigned PAD_LO = 2;
  localparam int unsigned PAD_HI = 6;

  // processor flag word bit positions
  localparam int unsigned FLAG_TRAP_EN = 22;
  localparam int unsigned FLAG_PAGE_EN = 23;
  localparam int unsigned FLAG_SPARE = 24;
  localparam int unsigned FLAG_TO_CONSOLE = 25;
  localparam int unsigned FLAG_POWER_FAIL = 26;
  localparam int unsigned FLAG_BAD_MEM = 27;
  localparam int unsigned FLAG_UNCORR = 28;
  localparam int unsigned FLAG_CORR = 29;
  localparam int unsigned FLAG_TIMER = 30;
  localparam int unsigned FLAG_CONSOLE_IN = 31;
  localparam int unsigned FLAG_REQ = 32;
  localparam logic [31:0] FLAG_RW_MASK = 32'h37c0_0000;
  localparam logic [31:0] FLAG_W1C_MASK = 32'hc800_0000;
  localparam logic [31:0] FLAG_SRC_MASK = 32'hfc00_0000;
  localparam logic [31:0] FLAG_RESET = 32'h0000_0000;
  localparam logic [3:0] FLAG_HI_FIXED = 4'h6;

  // register offsets (byte addresses)
  localparam int unsigned ADR_W = 8;
  localparam logic [ADR_W-1:0] REG_FLAG_LO = 8'h00;
  localparam logic [ADR_W-1:0] REG_FLAG_HI = 8'h04;
  localparam logic [ADR_W-1:0] REG_COUNT_LO = 8'h08;
  localparam logic [ADR_W-1:0] REG_COUNT_HI = 8'h0c;
  localparam logic [ADR_W-1:0] REG_IRQ_STAT = 8'h10;
  localparam logic [ADR_W-1:0] REG_IRQ_MASK = 8'h14;
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h18;

  // control register
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_LVL_LSB = 1;
  localparam int unsigned LVL_W = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // event status bits
  localparam int unsigned EV_W = 3;
  localparam int unsigned EV_TIMER = 0;
  localparam int unsigned EV_BAD_MEM = 1;
  localparam int unsigned EV_CONSOLE = 2;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

endpackage

// ==== core/frac_divider.sv ====
// fractional-n tick generator: 32-bit phase accumulator on a 50 MHz enable
// assumes en_i is a one-cycle enable at the system rate
`timescale 1ns/10ps
module frac_divider
  import itf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  output logic tick_o
);

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic carry;
  logic tick_q;

  // remainder stays in the accumulator so the long-term rate is exact
  assign {carry, acc_d} = {1'b0, acc_q} + {1'b0, ACC_INC};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      if (en_i)
        acc_q <= acc_d;
      tick_q <= en_i & carry;
    end
  end

  assign tick_o = tick_q;

  property p_acc_keeps_remainder;
    @(posedge clk_i) disable iff (rst_i)
    en_i |=> acc_q == ACC_W'($past(acc_q) + ACC_INC);
  endproperty
  a_acc_keeps_remainder: assert property (p_acc_keeps_remainder)
    else $error("accumulator did not keep its remainder");

  property p_tick_sparse;
    @(posedge clk_i) disable iff (rst_i)
    tick_q |=> !tick_q ##1 !tick_q;
  endproperty
  a_tick_sparse: assert property (p_tick_sparse)
    else $error("tick faster than the fractional rate allows");

endmodule // frac_divider

// ==== core/interval_count.sv ====
// interval timer: millisecond phase counter and 10 us fine count
// assumes tick_i is a one-cycle pulse at about 4.1 MHz
`timescale 1ns/10ps
module interval_count
  import itf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic run_i,
  output logic [FINE_W-1:0] fine_o,
  output logic ovf_o
);

  logic [PHASE_W-1:0] phase_q;
  logic [SUB_W-1:0] sub_q;
  logic [FINE_W-1:0] fine_q;
  logic msb_q;
  logic ovf_q;
  logic step;
  logic phase_wrap;
  logic sub_wrap;

  assign step = tick_i & run_i;
  assign phase_wrap = phase_q == PHASE_W'(MS_TICKS - 1);
  assign sub_wrap = sub_q == SUB_W'(FINE_TICKS - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_q <= '0;
      sub_q <= '0;
      fine_q <= '0;
      msb_q <= 1'b0;
      ovf_q <= 1'b0;
    end
    else
    begin
      if (step)
      begin
        phase_q <= phase_wrap ? '0 : phase_q + 1'b1;
        sub_q <= sub_wrap ? '0 : sub_q + 1'b1;
        if (sub_wrap)
          fine_q <= fine_q + 1'b1;
      end
      msb_q <= phase_q[PHASE_W-1];
      ovf_q <= msb_q & ~phase_q[PHASE_W-1];
    end
  end

  assign fine_o = fine_q;
  assign ovf_o = ovf_q;

  property p_ovf_on_msb_fall;
    @(posedge clk_i) disable iff (rst_i)
    $fell(phase_q[PHASE_W-1]) |-> ##1 ovf_q ##1 !ovf_q;
  endproperty
  a_ovf_on_msb_fall: assert property (p_ovf_on_msb_fall)
    else $error("overflow pulse missing after msb fall");

  property p_fine_step;
    @(posedge clk_i) disable iff (rst_i)
    step && sub_wrap |=> fine_q == FINE_W'($past(fine_q) + 1);
  endproperty
  a_fine_step: assert property (p_fine_step)
    else $error("fine count did not advance after 41 ticks");

endmodule // interval_count

// ==== core/interval_timer_and_flags.sv ====
// interval timer and processor flag block behind a classic wishbone slave
// assumes a single 100 MHz clock, synchronous reset and same-clock event pulses
//
// Functional notes
// - timer tick comes from 50 MHz via a 32-bit fractional-n accumulator, 4.100 MHz.
// - accumulator keeps the fractional remainder on overflow instead of clearing.
// - timer gives a 10 us fine count and a 1 ms periodic event.
// - overflow pulse lasts one cycle when the timer msb falls from one to zero.
// - count word bits 1:0 and top six bits are always zero.
// - interval-timer flag, bit 30, is set every 1.0 ms.
// - flag bits 24, 26, 28, 29 store and read back as written; 26, 28, 29 also raise the flag request.
// - flag bit 27 sets when a nonexistent memory location is accessed.
// - flag bit 31 sets when the console hands a character to the processor.
// - seven interrupt request lines, indexed 1 to 7, feed the priority block.
`timescale 1ns/10ps
module interval_timer_and_flags
  import itf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wb_req_t wb_req_i,
  output wb_rsp_t wb_rsp_o,
  input wire logic nonexistent_memory_i,
  input wire logic console_char_i,
  output logic timer_overflow_pulse_o,
  output logic [WORD_W-1:0] timer_count_word_o,
  output logic [7:1] flag_irq_lines_o,
  output logic trap_enable_o,
  output logic page_enable_o,
  output logic irq_o
);

  // byte lanes of a wishbone select, used by every writable register
  function automatic logic [31:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel);
    merge = (old & ~lanes(sel)) | (wdat & lanes(sel));
  endfunction

  // system-rate enable
  logic [SYS_CNT_W-1:0] sys_cnt_q;
  logic sys_en;

  assign sys_en = sys_cnt_q == SYS_CNT_W'(SYS_DIV - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sys_cnt_q <= '0;
    else
      sys_cnt_q <= sys_en ? '0 : sys_cnt_q + 1'b1;
  end

  // timer datapath
  logic tick;
  logic [FINE_W-1:0] fine;
  logic ovf;

  frac_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(sys_en),
    .tick_o(tick)
  );

  logic [31:0] ctrl_q;
  logic [LVL_W-1:0] lvl;

  assign lvl = ctrl_q[CTRL_LVL_LSB +: LVL_W];

  interval_count u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .run_i(ctrl_q[CTRL_RUN]),
    .fine_o(fine),
    .ovf_o(ovf)
  );

  // wishbone decode
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic wr_commit;
  logic [31:0] lane;
  logic flag_wr;
  logic stat_wr;
  logic mask_wr;
  logic ctrl_wr;

  assign req = wb_req_i.cyc & wb_req_i.stb;
  // writes take effect at the edge where the master samples ack
  assign wr_commit = req & wb_req_i.we & ack_q;
  assign lane = lanes(wb_req_i.sel);
  assign flag_wr = wr_commit & (wb_req_i.adr == REG_FLAG_LO);
  assign stat_wr = wr_commit & (wb_req_i.adr == REG_IRQ_STAT);
  assign mask_wr = wr_commit & (wb_req_i.adr == REG_IRQ_MASK);
  assign ctrl_wr = wr_commit & (wb_req_i.adr == REG_CTRL);

  // processor flag word
  logic [31:0] flag_q;
  logic [31:0] flag_d;
  logic [31:0] flag_rw;
  logic [31:0] flag_clr;
  logic [31:0] flag_set;
  logic flag_req;
  logic ovf_q;

  assign flag_rw = flag_wr ? merge(flag_q, wb_req_i.dat, wb_req_i.sel) : flag_q;
  assign flag_clr = flag_wr ? (wb_req_i.dat & lane & FLAG_W1C_MASK) : 32'h0000_0000;
  assign flag_set = (32'(ovf_q) << FLAG_TIMER)
    | (32'(nonexistent_memory_i) << FLAG_BAD_MEM)
    | (32'(console_char_i) << FLAG_CONSOLE_IN);
  // set wins over a clear in the same cycle so no event is lost
  assign flag_d = (flag_rw & FLAG_RW_MASK) | (flag_q & ~flag_clr & FLAG_W1C_MASK) | flag_set;
  assign flag_req = |(flag_q & FLAG_SRC_MASK);

  // event status and mask
  logic [EV_W-1:0] stat_q;
  logic [EV_W-1:0] stat_d;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] ev;

  assign ev = {console_char_i, nonexistent_memory_i, ovf_q};
  assign stat_d = (stat_q & ~(stat_wr ? wb_req_i.dat[EV_W-1:0] & lane[EV_W-1:0] : '0)) | ev;

  // read mux
  logic [31:0] rdat;
  logic [WORD_W-1:0] count_q;
  logic [7:1] irq_lines_d;

  assign rdat = (wb_req_i.adr == REG_FLAG_LO) ? flag_q
    : (wb_req_i.adr == REG_FLAG_HI) ? {28'h000_0000, FLAG_HI_FIXED[3:1], flag_req}
    : (wb_req_i.adr == REG_COUNT_LO) ? count_q[31:0]
    : (wb_req_i.adr == REG_COUNT_HI) ? {28'h000_0000, count_q[WORD_W-1:32]}
    : (wb_req_i.adr == REG_IRQ_STAT) ? 32'(stat_q)
    : (wb_req_i.adr == REG_IRQ_MASK) ? 32'(mask_q)
    : (wb_req_i.adr == REG_CTRL) ? ctrl_q
    : 32'h0000_0000;

  // one level carries the request; level zero parks it
  assign irq_lines_d = (flag_req && lvl != '0) ? 7'(8'h01 << (lvl - 1'b1)) : 7'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q)
        rdat_q <= rdat;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_q <= FLAG_RESET;
      stat_q <= EV_RESET;
      mask_q <= EV_RESET;
      ctrl_q <= CTRL_RESET;
      ovf_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      stat_q <= stat_d;
      ovf_q <= ovf;
      if (mask_wr)
        mask_q <= EV_W'(merge(32'(mask_q), wb_req_i.dat, wb_req_i.sel));
      if (ctrl_wr)
        ctrl_q <= merge(ctrl_q, wb_req_i.dat, wb_req_i.sel) & 32'h0000_000f;
    end
  end

  // registered outputs; the count is a one-cycle-old copy of the timer
  logic [7:1] irq_lines_q;
  logic irq_q;
  logic trap_q;
  logic page_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q <= '0;
      irq_lines_q <= 7'h00;
      irq_q <= 1'b0;
      trap_q <= 1'b0;
      page_q <= 1'b0;
    end
    else
    begin
      count_q <= {PAD_HI'(0), fine, PAD_LO'(0)};
      irq_lines_q <= irq_lines_d;
      irq_q <= |(stat_q & mask_q);
      trap_q <= flag_q[FLAG_TRAP_EN];
      page_q <= flag_q[FLAG_PAGE_EN];
    end
  end

  assign wb_rsp_o = '{ack: ack_q, dat: rdat_q};
  assign timer_overflow_pulse_o = ovf_q;
  assign timer_count_word_o = count_q;
  assign flag_irq_lines_o = irq_lines_q;
  assign trap_enable_o = trap_q;
  assign page_enable_o = page_q;
  assign irq_o = irq_q;

  property p_ovf_one_cycle;
    @(posedge clk_i) disable iff (rst_i)
    ovf_q |=> !ovf_q;
  endproperty
  a_ovf_one_cycle: assert property (p_ovf_one_cycle)
    else $error("overflow pulse longer than one cycle");

  property p_count_pads;
    @(posedge clk_i) disable iff (rst_i)
    ##1 (count_q[PAD_LO-1:0] == '0) && (count_q[WORD_W-1 -: PAD_HI] == '0);
  endproperty
  a_count_pads: assert property (p_count_pads)
    else $error("count word pad bits not zero");

  property p_timer_flag;
    @(posedge clk_i) disable iff (rst_i)
    ovf_q |=> flag_q[FLAG_TIMER] && stat_q[EV_TIMER];
  endproperty
  a_timer_flag: assert property (p_timer_flag)
    else $error("timer flag not set by overflow");

  property p_timer_flag_sticky;
    @(posedge clk_i) disable iff (rst_i)
    flag_q[FLAG_TIMER] && !flag_wr |=> flag_q[FLAG_TIMER];
  endproperty
  a_timer_flag_sticky: assert property (p_timer_flag_sticky)
    else $error("timer flag dropped without a write");

  property p_spare_stable;
    @(posedge clk_i) disable iff (rst_i)
    !flag_wr |=> $stable({flag_q[FLAG_SPARE], flag_q[FLAG_POWER_FAIL],
                          flag_q[FLAG_UNCORR], flag_q[FLAG_CORR]});
  endproperty
  a_spare_stable: assert property (p_spare_stable)
    else $error("storage-only flag changed without a write");

  property p_bad_mem_flag;
    @(posedge clk_i) disable iff (rst_i)
    nonexistent_memory_i |=> flag_q[FLAG_BAD_MEM];
  endproperty
  a_bad_mem_flag: assert property (p_bad_mem_flag)
    else $error("nonexistent memory flag not set");

  property p_console_flag;
    @(posedge clk_i) disable iff (rst_i)
    console_char_i |=> flag_q[FLAG_CONSOLE_IN] ##1 flag_req;
  endproperty
  a_console_flag: assert property (p_console_flag)
    else $error("console flag not set");

  property p_irq_lines;
    @(posedge clk_i) disable iff (rst_i)
    ##1 $onehot0(irq_lines_q) && (irq_lines_q != 7'h00 || !$past(flag_req) || $past(lvl) == '0);
  endproperty
  a_irq_lines: assert property (p_irq_lines)
    else $error("interrupt request lines inconsistent");

  property p_fixed_ones;
    @(posedge clk_i) disable iff (rst_i)
    ack_q && !wb_req_i.we && wb_req_i.adr == REG_FLAG_HI |-> wb_rsp_o.dat[2:1] == 2'b11;
  endproperty
  a_fixed_ones: assert property (p_fixed_ones)
    else $error("fixed flag bits not read as one");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  // a pending overflow wins over the clear, so it is left out here
  property p_stat_w1c;
    @(posedge clk_i) disable iff (rst_i)
    stat_wr && wb_req_i.dat[EV_TIMER] && wb_req_i.sel[0] && !ovf_q |=> !stat_q[EV_TIMER];
  endproperty
  a_stat_w1c: assert property (p_stat_w1c)
    else $error("status bit not cleared by a one");

  property p_irq_masked_low;
    @(posedge clk_i) disable iff (rst_i)
    (stat_q & mask_q) == '0 |=> !irq_q;
  endproperty
  a_irq_masked_low: assert property (p_irq_masked_low)
    else $error("irq raised with no unmasked status bit");

  property p_irq_unmasked_high;
    @(posedge clk_i) disable iff (rst_i)
    (stat_q & mask_q) != '0 |=> irq_q;
  endproperty
  a_irq_unmasked_high: assert property (p_irq_unmasked_high)
    else $error("irq low with an unmasked status bit");

endmodule // interval_timer_and_flags

// ==== verif/itf_far_side.sv ====
// far-side model: memory and console event sources, priority block inputs
// assumes the same clock as the flag block
`timescale 1ns/10ps
module itf_far_side
(
  input wire logic clk_i,
  input wire logic [7:1] irq_lines_i,
  output logic bad_mem_o,
  output logic char_o,
  output logic multi_o
);
  initial
  begin
    bad_mem_o = 1'b0;
    char_o = 1'b0;
    multi_o = 1'b0;
  end
  // one-cycle event, launched just after an edge
  task pulse(input logic is_char);
    @(posedge clk_i);
    if (is_char)
      char_o <= 1'b1;
    else
      bad_mem_o <= 1'b1;
    @(posedge clk_i);
    char_o <= 1'b0;
    bad_mem_o <= 1'b0;
  endtask
  // priority block can only take one level at a time
  always @(posedge clk_i)
    if ($countones(irq_lines_i) > 1)
      multi_o <= 1'b1;
endmodule // itf_far_side

// ==== verif/tb_top.sv ====
// self-checking bench for the interval timer and flag block
// assumes one 100 MHz clock; waits out one full millisecond for the timer
`timescale 1ns/10ps
module tb_top;
  import itf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  logic bad_mem, chr, ovf, trap, page, irq, multi;
  logic [WORD_W-1:0] cword, cap;
  logic [7:1] lines;
  logic [31:0] q, v, fl;
  logic [3:0] s;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int t_ovf;
  logic [7:0] ra [6] = '{REG_FLAG_LO, REG_FLAG_HI, REG_IRQ_STAT, REG_IRQ_MASK, REG_CTRL, 8'h1c};
  logic [31:0] re [6] = '{FLAG_RESET, 32'h6, 32'h0, 32'h0, CTRL_RESET, 32'h0};

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cycles <= rst_i ? 0 : cycles + 1;

  interval_timer_and_flags u_interval_timer_and_flags (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .nonexistent_memory_i(bad_mem), .console_char_i(chr),
    .timer_overflow_pulse_o(ovf), .timer_count_word_o(cword), .flag_irq_lines_o(lines),
    .trap_enable_o(trap), .page_enable_o(page), .irq_o(irq));
  itf_far_side u_far (.clk_i(clk_i), .irq_lines_i(lines), .bad_mem_o(bad_mem), .char_o(chr),
    .multi_o(multi));

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task check_word(input string name, input logic [35:0] exp, input logic [35:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task check_bit(input string name, input logic exp, input logic got);
    check_word(name, {35'h0, exp}, {35'h0, got});
  endtask

  // classic cycle; waits for ack with no fixed latency, the watchdog bounds a hang
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sl,
          output logic [31:0] rd);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: sl, dat: d};
    do
      @(posedge clk_i);
    while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    @(posedge clk_i);
    check_bit("ack_drop", 1'b0, rsp.ack);
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] sl);
    for (int b = 0; b < 4; b++)
      if (sl[b])
        o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction

  initial
  begin
    void'($urandom(32'hedcb));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h1c, $urandom, 4'hf, q);
    wb(1'b1, REG_COUNT_HI, 32'hf, 4'hf, q);
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b0, ra[i], 32'h0, 4'hf, q);
      check_word("reset_value", re[i], q);
    end
    wb(1'b0, REG_COUNT_HI, 32'h0, 4'hf, q);
    check_word("count_hi", 0, q);
    check_word("count_pads", 0, {cword[35:30], cword[1:0]});
    fl = 32'h0;
    repeat (8)
    begin
      v = $urandom;
      s = 4'($urandom);
      wb(1'b1, REG_FLAG_LO, v, s, q);
      fl = merge(fl, v, s) & FLAG_RW_MASK;
      wb(1'b0, REG_FLAG_LO, 32'h0, 4'hf, q);
      check_word("flag_lo", fl, q);
      wb(1'b0, REG_FLAG_HI, 32'h0, 4'hf, q);
      check_word("flag_hi", {29'h3, |fl[31:26]}, q);
      check_bit("trap_en", fl[FLAG_TRAP_EN], trap);
      check_bit("page_en", fl[FLAG_PAGE_EN], page);
    end
    wb(1'b1, REG_FLAG_LO, 32'h0, 4'hf, q);
    wb(1'b1, REG_IRQ_MASK, 32'h7, 4'hf, q);
    for (int lvl = 1; lvl < 8; lvl++)
    begin
      wb(1'b1, REG_CTRL, {28'h0, 3'(lvl), 1'b1}, 4'hf, q);
      u_far.pulse(lvl[0]);
      repeat (3) @(posedge clk_i);
      check_word("irq_lines", 36'h1 << (lvl - 1), lines);
      check_bit("irq", 1'b1, irq);
      wb(1'b0, REG_FLAG_LO, 32'h0, 4'hf, q);
      check_word("flag_lo", 32'h1 << (lvl[0] ? FLAG_CONSOLE_IN : FLAG_BAD_MEM), q);
      wb(1'b0, REG_IRQ_STAT, 32'h0, 4'hf, q);
      check_word("irq_stat", 32'h1 << (lvl[0] ? EV_CONSOLE : EV_BAD_MEM), q);
      wb(1'b1, REG_FLAG_LO, FLAG_W1C_MASK, 4'hf, q);
      wb(1'b1, REG_IRQ_STAT, 32'h7, 4'hf, q);
      repeat (3) @(posedge clk_i);
      check_bit("irq_clear", 1'b0, irq);
      check_word("lines_clear", 0, lines);
    end
    // masked event still latches status but keeps irq low
    wb(1'b1, REG_IRQ_MASK, 32'h1, 4'hf, q);
    u_far.pulse(1'b0);
    repeat (3) @(posedge clk_i);
    check_bit("irq_masked", 1'b0, irq);
    wb(1'b0, REG_IRQ_STAT, 32'h0, 4'hf, q);
    check_word("irq_stat_masked", 32'h1 << EV_BAD_MEM, q);
    wb(1'b1, REG_IRQ_STAT, 32'h7, 4'hf, q);
    wb(1'b1, REG_FLAG_LO, FLAG_W1C_MASK, 4'hf, q);
    check_bit("one_line", 1'b0, multi);
    do
      @(posedge clk_i);
    while (ovf !== 1'b1 && cycles < 120000);
    t_ovf = cycles;
    cap = cword;
    @(posedge clk_i);
    check_bit("ovf_width", 1'b0, ovf);
    check_bit("ovf_time", 1'b1, t_ovf inside {[99990:100020]});
    check_bit("fine", 1'b1, cap[29:2] inside {[MS_TICKS/FINE_TICKS-1:MS_TICKS/FINE_TICKS]});
    check_word("count_pads", 0, {cap[35:30], cap[1:0]});
    repeat (100) @(posedge clk_i);
    wb(1'b0, REG_FLAG_LO, 32'h0, 4'hf, q);
    check_word("timer_flag", 32'h1 << FLAG_TIMER, q);
    wb(1'b0, REG_IRQ_STAT, 32'h0, 4'hf, q);
    check_word("irq_stat", 32'h1 << EV_TIMER, q);
    check_bit("irq_timer", 1'b1, irq);
    wb(1'b1, REG_FLAG_LO, 32'h1 << FLAG_TIMER, 4'hf, q);
    wb(1'b0, REG_FLAG_LO, 32'h0, 4'hf, q);
    check_word("timer_flag_clr", 0, q);
    // run cleared: the fine count must hold over more than two of its steps
    wb(1'b1, REG_CTRL, 32'he, 4'hf, q);
    wb(1'b0, REG_COUNT_LO, 32'h0, 4'hf, v);
    repeat (2100) @(posedge clk_i);
    wb(1'b0, REG_COUNT_LO, 32'h0, 4'hf, q);
    check_word("count_frozen", v, q);
    stop_test;
  end

  // one millisecond plus margin for the register traffic
  initial
  begin
    repeat (125000) @(posedge clk_i);
    bad_count++;
    stop_test;
  end
endmodule // tb_top
